/* File: inc/hstp_pkg.sv */
// constants and carrier types for the hot-swap telemetry processing block
//
// Function
// - averaging code 000 reports each new sample unaveraged.
// - averaging code n averages two to the n samples, 1 up to 128.
// - peak and valley hold the extreme value seen since their last clear.
// - peaks kept for input voltage, output voltage, current, power, transistor temperature.
// - valleys kept for input voltage, output voltage, current, temperature; none for power.
// - each tracker is cleared by a host read and by power-on reset.
// - after clear a peak restarts at 0x000 and a valley at 0xFFF.
// - readings use direct format with 16-bit m and b and 8-bit exponent.
// - voltage coefficients are b 0, R -2, m 4653, 9307 or 18614 by range.
// - current slopes 23165, 11582, 5791, 28956 with exponents -2, -2, -2, -3.
// - rms current slopes 20808, 5202, 13005, 32513 with exponents -2, -2, -3, -4.
// - wide power coefficients depend on voltage range and sense range.
// - 16-bit power and energy coefficients depend on voltage and sense range.
// - rms current integrates samples over a window chosen by a 2-bit field.
// - each current sample is multiplied by the latest raw input voltage sample.
// - input power is readable as a 16-bit and a 24-bit value.
// - each power adds to the accumulator, counts a sample, counts rollovers.
// - energy read returns accumulator and counters captured at one instant.
// - the management interface becomes usable about 2 ms after power-up.
// - bus enabled by default; low enable pin disables it when so configured.
package hstp_pkg;
  localparam int          SAMPLE_W     = 12;
  localparam int          POWER_W      = 24;
  localparam int          ACC_W        = 24;
  localparam int          ROLL_W       = 8;
  localparam int          CNT_W        = 24;
  localparam int          AVG_SEL_W    = 3;
  localparam int          AVG_ACC_W    = SAMPLE_W + 7;
  localparam int          RMS_SEL_W    = 2;
  localparam int          RMS_ACC_W    = 32;
  localparam int          CLK_MHZ      = 25;
  localparam int          INIT_TIME_US = 2000;
  localparam int          INIT_CYCLES  = INIT_TIME_US * CLK_MHZ;
  localparam int          INIT_CNT_W   = 16;
  localparam logic [11:0] PEAK_CLEAR   = 12'h000;
  localparam logic [11:0] VALLEY_CLEAR = 12'hfff;
  localparam logic [2:0]  AVG_SINGLE   = 3'h0;
  localparam logic [2:0]  PIN_CFG_ENABLE = 3'h1;
  // rms window lengths in samples, by select code
  localparam logic [15:0] RMS_WIN_0    = 16'h0040;
  localparam logic [15:0] RMS_WIN_1    = 16'h0100;
  localparam logic [15:0] RMS_WIN_2    = 16'h0400;
  localparam logic [15:0] RMS_WIN_3    = 16'h1000;

  typedef enum logic [1:0] {
    HSTP_VR_88 = 2'b00,
    HSTP_VR_44 = 2'b01,
    HSTP_VR_22 = 2'b10
  } hstp_vrange_t;

  typedef enum logic [1:0] {
    HSTP_SR_12M5 = 2'b00,
    HSTP_SR_25M  = 2'b01,
    HSTP_SR_50M  = 2'b10,
    HSTP_SR_100M = 2'b11
  } hstp_srange_t;

  typedef struct packed {
    logic [15:0] m;
    logic [15:0] b;
    logic [7:0]  r;
  } hstp_coef_t;

  typedef struct packed {
    logic [ACC_W-1:0]  acc;
    logic [ROLL_W-1:0] roll;
    logic [CNT_W-1:0]  count;
  } hstp_energy_t;

  typedef struct packed {
    hstp_coef_t vin;
    hstp_coef_t iout;
    hstp_coef_t irms;
    hstp_coef_t pin_wide;
    hstp_coef_t pin_narrow;
    hstp_coef_t temp_ext;
    hstp_coef_t temp_die;
  } hstp_coef_set_t;
endpackage

/* File: design/hstp_avg.sv */
// power-of-two sample averager with per-channel select
`timescale 1ns/1ns
`default_nettype none
module hstp_avg #(
  parameter int W = 12
) (
  input  wire logic         core_clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         sample_valid_in,
  input  wire logic [W-1:0] sample_in,
  input  wire logic [2:0]   avg_sel_in,
  output logic              avg_valid_out,
  output logic [W-1:0]      avg_out
);
  localparam int AW = W + 7;
  logic [AW-1:0] acc_q;
  logic [6:0]    cnt_q;
  logic [6:0]    last_cnt;
  logic [AW-1:0] sum;
  logic          done;

  // count of 2^sel samples minus one
  assign last_cnt = 7'((8'h01 << avg_sel_in) - 8'h01);
  assign sum      = acc_q + AW'(sample_in);
  assign done     = sample_valid_in && (cnt_q >= last_cnt);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      acc_q         <= '0;
      cnt_q         <= '0;
      avg_valid_out <= 1'b0;
      avg_out       <= '0;
    end else begin
      avg_valid_out <= done;
      if (done) begin
        // code 000 shifts by zero: the raw sample passes
        avg_out <= W'(sum >> avg_sel_in);
        acc_q   <= '0;
        cnt_q   <= '0;
      end else if (sample_valid_in) begin
        acc_q <= sum;
        cnt_q <= cnt_q + 7'h01;
      end
    end
  end

  avg_single_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    sample_valid_in && avg_sel_in == 3'h0 |=> avg_valid_out && avg_out == $past(sample_in))
    else $error("unaveraged sample not passed through");
  avg_count_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    avg_valid_out |-> $past(cnt_q) == $past(last_cnt))
    else $error("average emitted at wrong sample count");
endmodule
`default_nettype wire

/* File: design/hstp_track.sv */
// peak or valley tracker with clear on read
`timescale 1ns/1ns
`default_nettype none
module hstp_track #(
  parameter int          W      = 12,
  parameter bit          IS_MAX = 1'b1,
  parameter logic [W-1:0] CLR   = '0
) (
  input  wire logic         core_clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         value_valid_in,
  input  wire logic [W-1:0] value_in,
  input  wire logic         read_clear_in,
  output logic [W-1:0]      hold_out
);
  logic          better;
  logic [W-1:0]  base;

  // a read clears, but a value in the same cycle still counts against the cleared base
  assign base   = read_clear_in ? CLR : hold_out;
  assign better = IS_MAX ? (value_in > base) : (value_in < base);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      hold_out <= CLR;
    end else if (value_valid_in && better) begin
      hold_out <= value_in;
    end else if (read_clear_in) begin
      hold_out <= CLR;
    end
  end

  track_extreme_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    value_valid_in && !read_clear_in |=>
      (IS_MAX ? hold_out >= $past(value_in) : hold_out <= $past(value_in)))
    else $error("tracker missed a new extreme");
  track_clear_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    read_clear_in && !value_valid_in |=> hold_out == CLR)
    else $error("tracker not cleared on read");
endmodule
`default_nettype wire

/* File: design/hstp_top.sv */
// telemetry post-processing: averaging, trackers, power, energy, rms, coefficients
`timescale 1ns/1ns
`default_nettype none
module hstp_top #(
  parameter int INIT_CYCLES = hstp_pkg::INIT_CYCLES
) (
  input  wire logic                      core_clk_in,
  input  wire logic                      sys_rst_in,
  input  wire logic                      vin_valid_in,
  input  wire logic [11:0]               vin_sample_in,
  input  wire logic                      vout_valid_in,
  input  wire logic [11:0]               vout_sample_in,
  input  wire logic                      iout_valid_in,
  input  wire logic [11:0]               iout_sample_in,
  input  wire logic                      temp_valid_in,
  input  wire logic [11:0]               temp_sample_in,
  input  wire logic [2:0]                v_avg_select_in,
  input  wire logic [2:0]                i_avg_select_in,
  input  wire logic [2:0]                p_avg_select_in,
  input  wire logic [1:0]                voltage_range_select_in,
  input  wire logic [1:0]                sense_range_select_in,
  input  wire logic [1:0]                rms_window_select_in,
  input  wire logic [2:0]                output_pin_config_in,
  input  wire logic                      general_output_three_in,
  input  wire logic                      rd_vin_peak_in,
  input  wire logic                      rd_vin_valley_in,
  input  wire logic                      rd_vout_peak_in,
  input  wire logic                      rd_vout_valley_in,
  input  wire logic                      rd_iout_peak_in,
  input  wire logic                      rd_iout_valley_in,
  input  wire logic                      rd_pin_peak_in,
  input  wire logic                      rd_temp_peak_in,
  input  wire logic                      rd_temp_valley_in,
  input  wire logic                      energy_read_in,
  output logic [11:0]                    vin_out,
  output logic [11:0]                    vout_out,
  output logic [11:0]                    iout_out,
  output logic [15:0]                    pin_narrow_out,
  output logic [23:0]                    input_power_wide_read_out,
  output logic [11:0]                    vin_peak_out,
  output logic [11:0]                    vin_valley_out,
  output logic [11:0]                    vout_peak_out,
  output logic [11:0]                    vout_valley_out,
  output logic [11:0]                    iout_peak_out,
  output logic [11:0]                    iout_valley_out,
  output logic [11:0]                    pin_peak_out,
  output logic [11:0]                    temp_peak_out,
  output logic [11:0]                    temp_valley_out,
  output logic [31:0]                    irms_sq_out,
  output hstp_pkg::hstp_energy_t         energy_read_out,
  output hstp_pkg::hstp_coef_set_t       coef_out,
  output logic                           bus_ready_out
);
  localparam int PW = hstp_pkg::POWER_W;
  localparam int RW = hstp_pkg::RMS_ACC_W;

  // synchronise the enable pin; first flop feeds only the second
  logic general_output_three_s1_q;
  logic general_output_three_s2_q;

  // latest raw voltage for power calculation
  logic [11:0] vin_raw_q;
  logic        pwr_valid_q;
  logic [PW-1:0] pwr_q;
  logic [PW-1:0] pwr_d;

  assign pwr_d = PW'(iout_sample_in) * PW'(vin_raw_q);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      vin_raw_q   <= '0;
      pwr_valid_q <= 1'b0;
      pwr_q       <= '0;
    end else begin
      if (vin_valid_in) begin
        vin_raw_q <= vin_sample_in;
      end
      pwr_valid_q <= iout_valid_in;
      if (iout_valid_in) begin
        pwr_q <= pwr_d;
      end
    end
  end

  // averaging; power averages its raw products, not averaged operands
  logic        vin_av_v, vout_av_v, iout_av_v, pin_av_v;
  logic [PW-1:0] pin_av;

  hstp_avg #(.W(12)) u_avg_vin (
    .core_clk_in    (core_clk_in),
    .sys_rst_in     (sys_rst_in),
    .sample_valid_in(vin_valid_in),
    .sample_in      (vin_sample_in),
    .avg_sel_in     (v_avg_select_in),
    .avg_valid_out  (vin_av_v),
    .avg_out        (vin_out)
  );
  hstp_avg #(.W(12)) u_avg_vout (
    .core_clk_in    (core_clk_in),
    .sys_rst_in     (sys_rst_in),
    .sample_valid_in(vout_valid_in),
    .sample_in      (vout_sample_in),
    .avg_sel_in     (v_avg_select_in),
    .avg_valid_out  (vout_av_v),
    .avg_out        (vout_out)
  );
  hstp_avg #(.W(12)) u_avg_iout (
    .core_clk_in    (core_clk_in),
    .sys_rst_in     (sys_rst_in),
    .sample_valid_in(iout_valid_in),
    .sample_in      (iout_sample_in),
    .avg_sel_in     (i_avg_select_in),
    .avg_valid_out  (iout_av_v),
    .avg_out        (iout_out)
  );
  hstp_avg #(.W(PW)) u_avg_pin (
    .core_clk_in    (core_clk_in),
    .sys_rst_in     (sys_rst_in),
    .sample_valid_in(pwr_valid_q),
    .sample_in      (pwr_q),
    .avg_sel_in     (p_avg_select_in),
    .avg_valid_out  (pin_av_v),
    .avg_out        (pin_av)
  );

  // both widths come from one averaged product
  assign input_power_wide_read_out = pin_av;
  assign pin_narrow_out            = pin_av[PW-1 -: 16];

  // trackers: peak index 0..4 (vin,vout,iout,pin,temp), valley index 0..3 (vin,vout,iout,temp; no power valley)
  localparam int NPK = 5;
  localparam int NVL = 4;
  logic [NPK-1:0]      pk_v, pk_rd;
  logic [NPK-1:0][11:0] pk_val, pk_hold;
  logic [NVL-1:0]      vl_v, vl_rd;
  logic [NVL-1:0][11:0] vl_val, vl_hold;

  assign pk_v   = {temp_valid_in, pin_av_v, iout_av_v, vout_av_v, vin_av_v};
  assign pk_val = {temp_sample_in, pin_av[PW-1 -: 12], iout_out, vout_out, vin_out};
  assign pk_rd  = {rd_temp_peak_in, rd_pin_peak_in, rd_iout_peak_in, rd_vout_peak_in,
                   rd_vin_peak_in};
  assign vl_v   = {temp_valid_in, iout_av_v, vout_av_v, vin_av_v};
  assign vl_val = {temp_sample_in, iout_out, vout_out, vin_out};
  assign vl_rd  = {rd_temp_valley_in, rd_iout_valley_in, rd_vout_valley_in, rd_vin_valley_in};

  // valid and value change on the same edge; a delayed valid would skip back-to-back results

  genvar gi;
  generate
    for (gi = 0; gi < NPK; gi++) begin : g_peak
      hstp_track #(.W(12), .IS_MAX(1'b1), .CLR(hstp_pkg::PEAK_CLEAR)) u_pk (
        .core_clk_in   (core_clk_in),
        .sys_rst_in    (sys_rst_in),
        .value_valid_in(pk_v[gi]),
        .value_in      (pk_val[gi]),
        .read_clear_in (pk_rd[gi]),
        .hold_out      (pk_hold[gi])
      );
    end
    for (gi = 0; gi < NVL; gi++) begin : g_valley
      hstp_track #(.W(12), .IS_MAX(1'b0), .CLR(hstp_pkg::VALLEY_CLEAR)) u_vl (
        .core_clk_in   (core_clk_in),
        .sys_rst_in    (sys_rst_in),
        .value_valid_in(vl_v[gi]),
        .value_in      (vl_val[gi]),
        .read_clear_in (vl_rd[gi]),
        .hold_out      (vl_hold[gi])
      );
    end
  endgenerate

  assign {temp_peak_out, pin_peak_out, iout_peak_out, vout_peak_out, vin_peak_out} = pk_hold;
  assign {temp_valley_out, iout_valley_out, vout_valley_out, vin_valley_out} = vl_hold;

  // energy accumulator; snapshot taken on the read strobe
  logic [hstp_pkg::ACC_W:0]      acc_sum;
  logic [hstp_pkg::ACC_W-1:0]    acc_q;
  logic [hstp_pkg::ROLL_W-1:0]   roll_q;
  logic [hstp_pkg::CNT_W-1:0]    cnt_q;

  assign acc_sum = {1'b0, acc_q} + {1'b0, pwr_q};

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      acc_q           <= '0;
      roll_q          <= '0;
      cnt_q           <= '0;
      energy_read_out <= '0;
    end else begin
      if (pwr_valid_q) begin
        acc_q <= acc_sum[hstp_pkg::ACC_W-1:0];
        cnt_q <= cnt_q + 1'b1;
        if (acc_sum[hstp_pkg::ACC_W]) begin
          roll_q <= roll_q + 1'b1;
        end
      end
      if (energy_read_in) begin
        energy_read_out <= '{acc: acc_q, roll: roll_q, count: cnt_q};
      end
    end
  end

  // rms: sum of squares over a selectable window
  logic [RW-1:0] sq_acc_q;
  logic [15:0]   win_cnt_q;
  logic [15:0]   win_len;
  logic [23:0]   sq;
  logic          win_end;

  assign win_len = (rms_window_select_in == 2'd0) ? hstp_pkg::RMS_WIN_0 :
                   (rms_window_select_in == 2'd1) ? hstp_pkg::RMS_WIN_1 :
                   (rms_window_select_in == 2'd2) ? hstp_pkg::RMS_WIN_2 :
                                                    hstp_pkg::RMS_WIN_3;
  assign sq      = 24'(iout_sample_in) * 24'(iout_sample_in);
  assign win_end = iout_valid_in && (win_cnt_q >= win_len - 16'h0001);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      sq_acc_q    <= '0;
      win_cnt_q   <= '0;
      irms_sq_out <= '0;
    end else if (win_end) begin
      irms_sq_out <= sq_acc_q + RW'(sq);
      sq_acc_q    <= '0;
      win_cnt_q   <= '0;
    end else if (iout_valid_in) begin
      sq_acc_q  <= sq_acc_q + RW'(sq);
      win_cnt_q <= win_cnt_q + 16'h0001;
    end
  end

  // direct-format coefficients
  function automatic hstp_pkg::hstp_coef_t mk(input int m, input int b, input int r);
    mk = '{m: 16'(m), b: 16'(b), r: 8'(r)};
  endfunction

  hstp_pkg::hstp_coef_set_t coef_d;
  always_comb begin
    coef_d.temp_ext = mk(52, 14321, -1);
    coef_d.temp_die = mk(23, 6225, -1);
    case (voltage_range_select_in)
      hstp_pkg::HSTP_VR_44: coef_d.vin = mk(9307, 0, -2);
      hstp_pkg::HSTP_VR_22: coef_d.vin = mk(18614, 0, -2);
      default:              coef_d.vin = mk(4653, 0, -2);
    endcase
    case (sense_range_select_in)
      hstp_pkg::HSTP_SR_12M5: begin
        coef_d.iout = mk(23165, 0, -2);
        coef_d.irms = mk(20808, 0, -2);
      end
      hstp_pkg::HSTP_SR_25M: begin
        coef_d.iout = mk(11582, 0, -2);
        coef_d.irms = mk(5202, 0, -2);
      end
      hstp_pkg::HSTP_SR_50M: begin
        coef_d.iout = mk(5791, 0, -2);
        coef_d.irms = mk(13005, 0, -3);
      end
      default: begin
        coef_d.iout = mk(28956, 0, -3);
        coef_d.irms = mk(32513, 0, -4);
      end
    endcase
    case ({voltage_range_select_in, sense_range_select_in})
      4'b0000: begin coef_d.pin_wide = mk(10780, 0, 0);  coef_d.pin_narrow = mk(4211, 0, -2); end
      4'b0001: begin coef_d.pin_wide = mk(5390, 0, 0);   coef_d.pin_narrow = mk(21054, 0, -3); end
      4'b0010: begin coef_d.pin_wide = mk(26949, 0, -1); coef_d.pin_narrow = mk(10527, 0, -3); end
      4'b0011: begin coef_d.pin_wide = mk(13474, 0, -1); coef_d.pin_narrow = mk(5263, 0, -3); end
      4'b0100: begin coef_d.pin_wide = mk(21559, 0, 0);  coef_d.pin_narrow = mk(8422, 0, -2); end
      4'b0101: begin coef_d.pin_wide = mk(10780, 0, 0);  coef_d.pin_narrow = mk(4211, 0, -2); end
      4'b0110: begin coef_d.pin_wide = mk(5390, 0, 0);   coef_d.pin_narrow = mk(21054, 0, -3); end
      4'b0111: begin coef_d.pin_wide = mk(26949, 0, -1); coef_d.pin_narrow = mk(10527, 0, -3); end
      4'b1000: begin coef_d.pin_wide = mk(4312, 0, 1);   coef_d.pin_narrow = mk(16843, 0, -2); end
      4'b1001: begin coef_d.pin_wide = mk(21559, 0, 0);  coef_d.pin_narrow = mk(8422, 0, -2); end
      4'b1010: begin coef_d.pin_wide = mk(10780, 0, 0);  coef_d.pin_narrow = mk(4211, 0, -2); end
      default: begin coef_d.pin_wide = mk(5390, 0, 0);   coef_d.pin_narrow = mk(21054, 0, -3); end
    endcase
  end

  // power-up wait and bus enable
  logic [hstp_pkg::INIT_CNT_W-1:0] init_cnt_q;
  logic                             init_done;
  assign init_done = (init_cnt_q == hstp_pkg::INIT_CNT_W'(INIT_CYCLES - 1));

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      init_cnt_q    <= '0;
      general_output_three_s1_q     <= 1'b1;
      general_output_three_s2_q     <= 1'b1;
      coef_out      <= '0;
      bus_ready_out <= 1'b0;
    end else begin
      general_output_three_s1_q <= general_output_three_in;
      general_output_three_s2_q <= general_output_three_s1_q;
      coef_out  <= coef_d;
      if (!init_done) begin
        init_cnt_q <= init_cnt_q + 1'b1;
      end
      bus_ready_out <= init_done &&
        !(output_pin_config_in == hstp_pkg::PIN_CFG_ENABLE && !general_output_three_s2_q);
    end
  end

  energy_snap_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    energy_read_in |=> energy_read_out.count == $past(cnt_q) && energy_read_out.acc == $past(acc_q))
    else $error("energy snapshot inconsistent");
  power_calc_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    iout_valid_in |=> pwr_q == PW'($past(iout_sample_in)) * PW'($past(vin_raw_q)))
    else $error("power product wrong");
  energy_count_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    pwr_valid_q |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("sample counter did not step");
  bus_gate_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    output_pin_config_in == hstp_pkg::PIN_CFG_ENABLE && !general_output_three_s2_q |=> !bus_ready_out)
    else $error("bus enabled while pin low");
  volt_coef_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    voltage_range_select_in == 2'b01 |=> coef_out.vin.m == 16'd9307 && coef_out.vin.r == 8'hfe)
    else $error("voltage coefficient wrong");
  temp_coef_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    1'b1 |=> coef_out.temp_ext.b == 16'd14321)
    else $error("temperature offset wrong");
endmodule
`default_nettype wire

/* File: bench/hstp_host.sv */
// host model: issues energy reads and time-stamps them
`timescale 1ns/1ns
`default_nettype none
module hstp_host (
  input  wire logic                   core_clk_in,
  input  wire logic                   req_in,
  input  wire hstp_pkg::hstp_energy_t energy_in,
  output logic                        energy_read_out,
  output logic [23:0]                 delta_out,
  output int                          stamp_out
);
  logic        got_q  = 1'b0;
  logic [23:0] last_q = '0;
  int          cyc_q  = 0;
  always @(posedge core_clk_in) begin
    cyc_q <= cyc_q + 1;
    energy_read_out <= req_in;
    got_q <= energy_read_out;
    // energy comes from the accumulator difference between two stamped reads
    if (got_q) begin
      delta_out <= energy_in.acc - last_q;
      last_q <= energy_in.acc;
      stamp_out <= cyc_q;
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench for the telemetry processing block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic                     clk, rst, req, gpo, er, rdy;
  logic [3:0]               vld;
  logic [11:0]              smp, vo, vpk, vvl, tpk, tvl;
  logic [2:0]               vsel, cfg;
  logic [1:0]               vr, sr;
  logic [8:0]               rd;
  logic [15:0]              pn;
  logic [23:0]              pw, dl;
  logic [31:0]              rq;
  int                       error_cnt, tests_run, n;
  hstp_pkg::hstp_energy_t   en;
  hstp_pkg::hstp_coef_set_t cf;
  localparam logic [15:0] VM[3] = '{16'h122d, 16'h245b, 16'h48b6};
  localparam logic [15:0] IM[4] = '{16'h5a7d, 16'h2d3e, 16'h169f, 16'h711c};
  localparam logic [15:0] RM[4] = '{16'h5148, 16'h1452, 16'h32cd, 16'h7f01};
  localparam logic [7:0]  IR[4] = '{8'hfe, 8'hfe, 8'hfe, 8'hfd};
  localparam logic [7:0]  RR[4] = '{8'hfe, 8'hfe, 8'hfd, 8'hfc};
  hstp_top #(.INIT_CYCLES(20)) i_hstp_top (
    .core_clk_in(clk), .sys_rst_in(rst), .vin_valid_in(vld[0]), .vin_sample_in(smp),
    .vout_valid_in(vld[1]), .vout_sample_in(smp), .iout_valid_in(vld[2]), .iout_sample_in(smp),
    .temp_valid_in(vld[3]), .temp_sample_in(smp), .v_avg_select_in(vsel),
    .i_avg_select_in(3'h0), .p_avg_select_in(3'h0), .voltage_range_select_in(vr),
    .sense_range_select_in(sr), .rms_window_select_in(2'h0), .output_pin_config_in(cfg),
    .general_output_three_in(gpo), .rd_vin_peak_in(rd[0]), .rd_vin_valley_in(rd[1]),
    .rd_vout_peak_in(rd[2]), .rd_vout_valley_in(rd[3]), .rd_iout_peak_in(rd[4]),
    .rd_iout_valley_in(rd[5]), .rd_pin_peak_in(rd[6]), .rd_temp_peak_in(rd[7]),
    .rd_temp_valley_in(rd[8]), .energy_read_in(er), .vin_out(vo), .vout_out(), .iout_out(),
    .pin_narrow_out(pn), .input_power_wide_read_out(pw), .vin_peak_out(vpk),
    .vin_valley_out(vvl), .vout_peak_out(), .vout_valley_out(), .iout_peak_out(),
    .iout_valley_out(), .pin_peak_out(), .temp_peak_out(tpk), .temp_valley_out(tvl),
    .irms_sq_out(rq), .energy_read_out(en), .coef_out(cf), .bus_ready_out(rdy));
  hstp_host i_hstp_host (.core_clk_in(clk), .req_in(req), .energy_in(en),
    .energy_read_out(er), .delta_out(dl), .stamp_out());
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task put(input int ch, input logic [11:0] v);
    vld[ch] = 1'b1;
    smp = v;
    cyc(1);
    vld = '0;
    // a released sample bus never keeps the last value
    smp = ~v;
    // idle edge so that a following call never re-drives valid in the same step
    cyc(1);
  endtask
  task results;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #100000;
    error_cnt++;
    results;
  end
  initial begin
    {vld, rd, req, vsel, vr, sr} = '0;
    {smp, cfg, gpo, rst} = {12'h000, 3'h1, 1'b1, 1'b1};
    error_cnt = 0;
    tests_run = 0;
    cyc(4);
    chk("valley rst", 12'hfff, vvl);
    chk("peak rst", 12'h000, vpk);
    rst = 1'b0;
    cyc(19);
    chk("ready early", 1'b0, rdy);
    cyc(3);
    chk("ready", 1'b1, rdy);
    put(0, 12'h010);
    cyc(1);
    chk("vin single", 12'h010, vo);
    put(2, 12'h020);
    put(2, 12'h030);
    cyc(2);
    chk("pin wide", 24'h00_0300, pw);
    chk("pin narrow", 16'h0003, pn);
    req = 1'b1;
    cyc(1);
    req = 1'b0;
    cyc(3);
    chk("acc", 24'h00_0500, en.acc);
    chk("count", 24'h00_0002, en.count);
    chk("roll", 8'h00, en.roll);
    chk("delta", 24'h00_0500, dl);
    put(0, 12'h300);
    put(0, 12'h100);
    cyc(3);
    chk("vin peak", 12'h300, vpk);
    chk("vin valley", 12'h010, vvl);
    rd[0] = 1'b1;
    cyc(1);
    rd[0] = 1'b0;
    cyc(1);
    chk("peak clr", 12'h000, vpk);
    put(0, 12'h050);
    cyc(3);
    chk("peak new", 12'h050, vpk);
    vsel = 3'h1;
    put(0, 12'h100);
    put(0, 12'h200);
    cyc(1);
    chk("vin avg2", 12'h180, vo);
    vsel = 3'h7;
    repeat (64) put(0, 12'h0c8);
    cyc(1);
    chk("avg128 half", 12'h180, vo);
    repeat (64) put(0, 12'h0c8);
    cyc(1);
    chk("avg128", 12'h0c8, vo);
    put(3, 12'h123);
    cyc(3);
    chk("temp peak", 12'h123, tpk);
    chk("temp valley", 12'h123, tvl);
    chk("pwide m", 16'h2a1c, cf.pin_wide.m);
    chk("pnarrow m", 16'h1073, cf.pin_narrow.m);
    for (n = 0; n < 3; n++) begin
      vr = n[1:0];
      cyc(2);
      chk("vin m", VM[n], cf.vin.m);
      chk("vin r", 8'hfe, cf.vin.r);
    end
    for (n = 0; n < 4; n++) begin
      sr = n[1:0];
      cyc(2);
      chk("iout m", IM[n], cf.iout.m);
      chk("iout r", IR[n], cf.iout.r);
      chk("irms m", RM[n], cf.irms.m);
      chk("irms r", RR[n], cf.irms.r);
    end
    chk("pwide 22", 16'h150e, cf.pin_wide.m);
    chk("pnarrow 22", 16'h523e, cf.pin_narrow.m);
    chk("text b", 16'h37f1, cf.temp_ext.b);
    chk("tdie b", 16'h1851, cf.temp_die.b);
    // two current samples already sit in the 64-sample window: 0x400 + 0x900
    repeat (62) put(2, 12'h010);
    cyc(1);
    chk("irms sq", 32'h0000_4b00, rq);
    gpo = 1'b0;
    cyc(4);
    chk("bus off", 1'b0, rdy);
    cfg = 3'h0;
    cyc(4);
    chk("bus on", 1'b1, rdy);
    results;
  end
endmodule
`default_nettype wire
